// ==== dv/tb_usb_sie_status_control_token.sv ====
// self-checking bench of the link status and control registers over axi4-lite.
// assumes the far-end model drives the engine side; the frame count is shortened.
`default_nettype none
module tb_usb_sie_status_control_token;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SOF_N = 20;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic cmd_xfer = 1'b0, cmd_setup = 1'b0;
  logic [5:0] cmd_info = 6'h00, tok_delay = 6'h0A;
  logic [2:0] cmd_line = 3'h4;
  logic xfer_done, setup_rcvd, token_done;
  logic [5:0] xfer_info;
  logic [2:0] line;
  logic dp_pu, dm_pu, dp_pd, dm_pd, mod_en, host, halt, ppclr, resume, busrst, lowspd, tok_start, sof;
  logic [6:0] faddr;
  logic [3:0] tok_type, tok_endpoint;
  logic [7:0] sof_thr;
  int num_errors = 0, checks_done = 0, cyc = 0, tok_total = 0, sof_total = 0, sof_last = 0, sof_gap = 0, n0;
  logic [3:0] codes [3] = '{4'hD, 4'h9, 4'h1};

  usb_sie_ctrl #(.SOF_CYCLES(SOF_N)) usb_sie_ctrl_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_xfer_done(xfer_done),
    .i_xfer_endpoint(xfer_info[5:2]), .i_xfer_tx(xfer_info[1]), .i_xfer_odd(xfer_info[0]),
    .i_setup_rcvd(setup_rcvd), .i_token_done(token_done), .i_line_dp(line[2]), .i_line_dm(line[1]),
    .i_line_se0(line[0]), .o_dp_pullup(dp_pu), .o_dm_pullup(dm_pu), .o_dp_pulldown(dp_pd),
    .o_dm_pulldown(dm_pd), .o_module_enable(mod_en), .o_host_mode(host), .o_packet_halt(halt),
    .o_pingpong_clear(ppclr), .o_resume_drive(resume), .o_bus_reset_drive(busrst), .o_low_speed(lowspd),
    .o_function_address(faddr), .o_token_start(tok_start), .o_token_type(tok_type),
    .o_token_endpoint(tok_endpoint), .o_frame_start(sof), .o_frame_threshold(sof_thr));

  usb_far_end_model usb_far_end_model_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_xfer(cmd_xfer), .i_cmd_info(cmd_info),
    .i_cmd_setup(cmd_setup), .i_cmd_line(cmd_line), .i_token_delay(tok_delay), .i_token_start(tok_start),
    .o_xfer_done(xfer_done), .o_xfer_info(xfer_info), .o_setup_rcvd(setup_rcvd),
    .o_token_done(token_done), .o_line(line));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (tok_start === 1'b1) tok_total <= tok_total + 1;
    if (sof === 1'b1) begin
      sof_total <= sof_total + 1;
      sof_last <= cyc;
      sof_gap <= cyc - sof_last;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    // no cycle limit: only the watchdog ends a wait that is never answered
    do begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge i_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic xfer(input logic [5:0] info);
    @(posedge i_clk);
    cmd_xfer <= 1'b1;
    cmd_info <= info;
    @(posedge i_clk);
    cmd_xfer <= 1'b0;
    tick(2);
  endtask : xfer

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    tick(16);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0, 2'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'hFF, 2'h2);
    wr(8'h08, 32'hFFFF_FFFF, 2'h0);
    rd(8'h08, 32'h7F, 2'h0);
    tick(3);
    chk({24'h0, faddr, lowspd}, 32'hFE);
    $display("test reset and address done");
    wr(8'h04, 32'h01, 2'h0);
    tick(3);
    chk({27'h0, mod_en, dp_pu, dm_pu, dp_pd, dm_pd}, 32'h18);
    cmd_setup <= 1'b1;
    @(posedge i_clk);
    cmd_setup <= 1'b0;
    tick(3);
    chk({31'h0, halt}, 32'h1);
    rd(8'h04, 32'h21, 2'h0);
    wr(8'h04, 32'h03, 2'h0);
    tick(3);
    chk({30'h0, halt, ppclr}, 32'h1);
    cmd_line <= 3'h1;
    tick(4);
    rd(8'h04, 32'h43, 2'h0);
    cmd_line <= 3'h4;
    for (int k = 0; k < 4; k++) begin
      xfer({4'(k * 5), k[0], k[1]});
      rd(8'h00, {24'h0, 4'(k * 5), k[0], k[1], 2'b00}, 2'h0);
    end
    wr(8'h04, 32'h00, 2'h0);
    tick(3);
    chk({31'h0, dp_pu}, 32'h0);
    $display("test device view done");
    wr(8'h08, 32'h00, 2'h0);
    // the bus reset bit exists only in the host view, so enter host mode first
    wr(8'h04, 32'h08, 2'h0);
    wr(8'h04, 32'h1C, 2'h0);
    tick(3);
    chk({26'h0, host, dp_pu, dp_pd, dm_pd, busrst, resume}, 32'h2F);
    rd(8'h04, 32'h9C, 2'h0);
    wr(8'h04, 32'h08, 2'h0);
    wr(8'h08, 32'h80, 2'h0);
    cmd_line <= 3'h2;
    tick(4);
    chk({30'h0, lowspd, busrst}, 32'h2);
    rd(8'h04, 32'h88, 2'h0);
    wr(8'h08, 32'h00, 2'h0);
    cmd_line <= 3'h4;
    wr(8'h10, 32'h4A, 2'h0);
    rd(8'h10, 32'h4A, 2'h0);
    chk({24'h0, sof_thr}, 32'h4A);
    $display("test host view done");
    for (int k = 0; k < 3; k++) begin
      tok_delay <= 6'(12 + k * 10);
      n0 = tok_total;
      wr(8'h0C, {24'h0, codes[k], 4'(k + 3)}, 2'h0);
      rd(8'h04, 32'hA8, 2'h0);
      tick(40);
      chk(tok_total - n0, 32'h1);
      chk({24'h0, tok_type, tok_endpoint}, {24'h0, codes[k], 4'(k + 3)});
      rd(8'h04, 32'h88, 2'h0);
    end
    $display("test tokens done");
    wr(8'h04, 32'h09, 2'h0);
    n0 = sof_total;
    tick(3 * SOF_N + 5);
    chk(sof_total - n0, 32'h3);
    chk(sof_gap, SOF_N);
    wr(8'h04, 32'h08, 2'h0);
    tick(2);
    n0 = sof_total;
    tick(3 * SOF_N);
    chk(sof_total - n0, 32'h0);
    $display("test frame start done");
    // reserved codes are stored as well, but the no-launch path is shown with a setup code in device mode
    wr(8'h04, 32'h00, 2'h0);
    n0 = tok_total;
    wr(8'h0C, 32'hD3, 2'h0);
    tick(5);
    chk(tok_total - n0, 32'h0);
    rd(8'h0C, 32'hD3, 2'h0);
    wr(8'h14, 32'hF1, 2'h0);
    tick(3);
    chk({28'h0, dp_pu, dm_pu, dp_pd, dm_pd}, 32'hF);
    rd(8'h14, 32'hF1, 2'h0);
    $display("test device token and manual pulls done");
    wrap_up();
  end

  initial begin
    tick(4000);
    num_errors++;
    wrap_up();
  end
endmodule : tb_usb_sie_status_control_token
`default_nettype wire

// ==== dv/usb_far_end_model.sv ====
// far-end model: the serial engine and bus lines that feed the register block.
// assumes bench commands change just after a rising edge of i_clk.
`default_nettype none
module usb_far_end_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_xfer,
  input wire logic [5:0] i_cmd_info,
  input wire logic i_cmd_setup,
  input wire logic [2:0] i_cmd_line,
  input wire logic [5:0] i_token_delay,
  input wire logic i_token_start,
  output logic o_xfer_done,
  output logic [5:0] o_xfer_info,
  output logic o_setup_rcvd,
  output logic o_token_done,
  output logic [2:0] o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] tok_wait;
  // outside a completion pulse the fields toggle, so stale values never look valid
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_xfer_done <= 1'b0;
      o_xfer_info <= 6'h00;
      o_setup_rcvd <= 1'b0;
      o_line <= 3'h4;
    end else begin
      o_xfer_done <= i_cmd_xfer;
      o_xfer_info <= i_cmd_xfer ? i_cmd_info : ~o_xfer_info;
      o_setup_rcvd <= i_cmd_setup;
      o_line <= i_cmd_line;
    end
  end
  // a token ends after a settable delay, prompt or slow
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tok_wait <= 6'h00;
      o_token_done <= 1'b0;
    end else begin
      o_token_done <= (tok_wait == 6'h01);
      if (i_token_start) tok_wait <= i_token_delay;
      else if (tok_wait != 6'h00) tok_wait <= tok_wait - 6'h01;
    end
  end
endmodule : usb_far_end_model
`default_nettype wire

// ==== hdl/usb_sie_ctrl.sv ====
// status, control, address, token and frame threshold registers of a usb
// serial interface engine, reached over axi4-lite.
// assumes the engine's strobes and line levels are synchronous to i_clk.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`include "usb_sie_map.svh"
`default_nettype none
module usb_sie_ctrl
  import usb_sie_pkg::*;
#(
  parameter int SOF_CYCLES = `SOF_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_xfer_done,
  input wire logic [3:0] i_xfer_endpoint,
  input wire logic i_xfer_tx,
  input wire logic i_xfer_odd,
  input wire logic i_setup_rcvd,
  input wire logic i_token_done,
  input wire logic i_line_dp,
  input wire logic i_line_dm,
  input wire logic i_line_se0,
  output logic o_dp_pullup,
  output logic o_dm_pullup,
  output logic o_dp_pulldown,
  output logic o_dm_pulldown,
  output logic o_module_enable,
  output logic o_host_mode,
  output logic o_packet_halt,
  output logic o_pingpong_clear,
  output logic o_resume_drive,
  output logic o_bus_reset_drive,
  output logic o_low_speed,
  output logic [6:0] o_function_address,
  output logic o_token_start,
  output logic [3:0] o_token_type,
  output logic [3:0] o_token_endpoint,
  output logic o_frame_start,
  output logic [7:0] o_frame_threshold
);

  function automatic reg_sel_t decode(input logic [7:0] a);
    unique case (a)
      `OFS_STAT: decode = SEL_STAT;
      `OFS_CTRL: decode = SEL_CTRL;
      `OFS_ADDR: decode = SEL_ADDR;
      `OFS_TOK: decode = SEL_TOK;
      `OFS_SOF: decode = SEL_SOF;
      `OFS_OTG: decode = SEL_OTG;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  logic [3:0] last_endpoint_number;
  logic last_dir_tx;
  logic pingpong_bank_flag;
  logic live_se0_flag;
  logic live_j_level_flag;
  logic packet_processing_halt;
  logic host_capability_enable;
  logic module_attach_enable;
  logic resume_drive;
  logic pingpong_pointer_clear;
  logic bus_reset_drive;
  logic frame_start_enable;
  logic token_in_progress;
  logic low_speed_select;
  logic [6:0] function_address;
  logic [3:0] token_type;
  logic [3:0] token_endpoint;
  logic [7:0] frame_start_threshold_value;
  logic on_the_go_features_enable;
  logic [3:0] manual_pulls;
  logic [7:0] waddr;
  logic [7:0] wbyte;
  logic wlane;
  logic do_write;
  reg_sel_t wsel;
  logic [7:0] rbyte;
  logic [15:0] frame_count;

  // write happens once address and data are both held and no response waits
  assign do_write = !o_awready && !o_wready && !o_bvalid;
  assign wsel = decode(waddr);

  // axi write channels: address and data taken in either order
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      waddr <= 8'h00;
      wbyte <= 8'h00;
      wlane <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        waddr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        wbyte <= i_wdata[7:0];
        wlane <= i_wstrb[0];
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // register read view; bits above the low byte always read zero
  always_comb begin
    rbyte = 8'h00;
    unique case (decode(i_araddr))
      SEL_STAT: rbyte = {last_endpoint_number, last_dir_tx, pingpong_bank_flag, 2'b00};
      SEL_CTRL: begin
        if (host_capability_enable) begin
          rbyte = {live_j_level_flag, live_se0_flag, token_in_progress, bus_reset_drive,
                   host_capability_enable, resume_drive, pingpong_pointer_clear, frame_start_enable};
        end else begin
          rbyte = {1'b0, live_se0_flag, packet_processing_halt, 1'b0,
                   host_capability_enable, resume_drive, pingpong_pointer_clear, module_attach_enable};
        end
      end
      SEL_ADDR: rbyte = {low_speed_select & host_capability_enable, function_address};
      SEL_TOK: rbyte = {token_type, token_endpoint};
      SEL_SOF: rbyte = frame_start_threshold_value;
      SEL_OTG: rbyte = {manual_pulls, 3'b000, on_the_go_features_enable};
      SEL_NONE: rbyte = 8'h00;
    endcase
  end

  // axi read channel: one read at a time, answered the cycle after it is taken
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= {24'h000000, rbyte};
      o_rresp <= (decode(i_araddr) == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // the three status fields move as one so a read never mixes transfers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_endpoint_number <= 4'h0;
      last_dir_tx <= 1'b0;
      pingpong_bank_flag <= 1'b0;
    end else if (i_xfer_done) begin
      last_endpoint_number <= i_xfer_endpoint;
      last_dir_tx <= i_xfer_tx;
      pingpong_bank_flag <= i_xfer_odd;
    end
  end

  // live line flags; j is differential one at full speed, zero at low speed
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      live_se0_flag <= 1'b0;
      live_j_level_flag <= 1'b0;
    end else begin
      live_se0_flag <= i_line_se0;
      live_j_level_flag <= host_capability_enable && (low_speed_select ? (!i_line_dp && i_line_dm)
                                                      : (i_line_dp && !i_line_dm));
    end
  end

  // control bits; bit 0 and bits 4-5 mean different things per mode
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      host_capability_enable <= 1'b0;
      module_attach_enable <= 1'b0;
      resume_drive <= 1'b0;
      pingpong_pointer_clear <= 1'b0;
      bus_reset_drive <= 1'b0;
      frame_start_enable <= 1'b0;
    end else if (do_write && wlane && wsel == SEL_CTRL) begin
      host_capability_enable <= wbyte[`BIT_CTRL_HOST];
      resume_drive <= wbyte[`BIT_CTRL_RESUME];
      pingpong_pointer_clear <= wbyte[`BIT_CTRL_PPCLR];
      if (host_capability_enable) begin
        bus_reset_drive <= wbyte[`BIT_CTRL_BUSRST];
        frame_start_enable <= wbyte[`BIT_CTRL_EN];
      end else begin
        module_attach_enable <= wbyte[`BIT_CTRL_EN];
      end
    end
  end

  // a setup token arriving with a software clear still halts processing
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      packet_processing_halt <= 1'b0;
    end else if (i_setup_rcvd && !host_capability_enable) begin
      packet_processing_halt <= 1'b1;
    end else if (do_write && wlane && wsel == SEL_CTRL && !host_capability_enable) begin
      packet_processing_halt <= wbyte[`BIT_CTRL_HALT];
    end
  end

  // address, threshold and otg pull settings
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_speed_select <= 1'b0;
      function_address <= 7'h00;
      frame_start_threshold_value <= `RST_BYTE;
      on_the_go_features_enable <= 1'b0;
      manual_pulls <= 4'h0;
    end else if (do_write && wlane) begin
      if (wsel == SEL_ADDR) begin
        low_speed_select <= wbyte[`BIT_ADDR_LS] & host_capability_enable;
        function_address <= wbyte[6:0];
      end
      if (wsel == SEL_SOF) begin
        frame_start_threshold_value <= wbyte;
      end
      if (wsel == SEL_OTG) begin
        on_the_go_features_enable <= wbyte[`BIT_OTG_EN];
        manual_pulls <= wbyte[`BIT_OTG_DPPU:`BIT_OTG_DMPD];
      end
    end
  end

  // token issue: completion and a new launch in one cycle leave it busy
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      token_type <= 4'h0;
      token_endpoint <= 4'h0;
      token_in_progress <= 1'b0;
      o_token_start <= 1'b0;
    end else begin
      o_token_start <= 1'b0;
      if (i_token_done) begin
        token_in_progress <= 1'b0;
      end
      if (do_write && wlane && wsel == SEL_TOK) begin
        token_type <= wbyte[7:4];
        token_endpoint <= wbyte[3:0];
        // reserved codes are stored but never launched
        if (host_capability_enable && (wbyte[7:4] == TOK_SETUP || wbyte[7:4] == TOK_IN
                                       || wbyte[7:4] == TOK_OUT)) begin
          token_in_progress <= 1'b1;
          o_token_start <= 1'b1;
        end
      end
    end
  end

  // one millisecond frame tick, host mode only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_count <= 16'h0000;
      o_frame_start <= 1'b0;
    end else if (host_capability_enable && frame_start_enable) begin
      o_frame_start <= (frame_count == 16'(SOF_CYCLES - 1));
      frame_count <= (frame_count == 16'(SOF_CYCLES - 1)) ? 16'h0000 : frame_count + 16'h0001;
    end else begin
      frame_count <= 16'h0000;
      o_frame_start <= 1'b0;
    end
  end

  // line pulls and drive outputs, all registered
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dp_pullup <= 1'b0;
      o_dm_pullup <= 1'b0;
      o_dp_pulldown <= 1'b0;
      o_dm_pulldown <= 1'b0;
      o_module_enable <= 1'b0;
      o_host_mode <= 1'b0;
      o_packet_halt <= 1'b0;
      o_pingpong_clear <= 1'b0;
      o_resume_drive <= 1'b0;
      o_bus_reset_drive <= 1'b0;
      o_low_speed <= 1'b0;
      o_function_address <= 7'h00;
      o_token_type <= 4'h0;
      o_token_endpoint <= 4'h0;
      o_frame_threshold <= 8'h00;
    end else begin
      if (on_the_go_features_enable) begin
        {o_dp_pullup, o_dm_pullup, o_dp_pulldown, o_dm_pulldown} <= manual_pulls;
      end else begin
        o_dp_pullup <= module_attach_enable && !host_capability_enable;
        o_dm_pullup <= 1'b0;
        o_dp_pulldown <= host_capability_enable;
        o_dm_pulldown <= host_capability_enable;
      end
      o_module_enable <= module_attach_enable || host_capability_enable;
      o_host_mode <= host_capability_enable;
      o_packet_halt <= packet_processing_halt && !host_capability_enable;
      o_pingpong_clear <= pingpong_pointer_clear;
      o_resume_drive <= resume_drive;
      o_bus_reset_drive <= bus_reset_drive && host_capability_enable;
      o_low_speed <= low_speed_select && host_capability_enable;
      o_function_address <= function_address;
      o_token_type <= token_type;
      o_token_endpoint <= token_endpoint;
      o_frame_threshold <= frame_start_threshold_value;
    end
  end

  a_status_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_xfer_done |=> last_endpoint_number == $past(i_xfer_endpoint) && last_dir_tx == $past(i_xfer_tx)
                    && pingpong_bank_flag == $past(i_xfer_odd))
    else $error("status fields did not load together");

  a_se0_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 live_se0_flag == $past(i_line_se0))
    else $error("se0 flag does not follow the line");

  a_setup_halt: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_setup_rcvd && !host_capability_enable |=> packet_processing_halt ##1 o_packet_halt)
    else $error("setup token did not halt processing");

  a_host_pulls: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    host_capability_enable && !on_the_go_features_enable |=> o_dp_pulldown && o_dm_pulldown && !o_dp_pullup)
    else $error("host pull-downs not applied");

  a_attach_pullup: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !on_the_go_features_enable |=> o_dp_pullup == $past(module_attach_enable && !host_capability_enable))
    else $error("attach pull-up wrong");

  a_bus_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_bus_reset_drive |-> $past(bus_reset_drive) && o_host_mode)
    else $error("bus reset driven outside host mode");

  a_token_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_token_start |-> token_in_progress && !$past(token_in_progress && !i_token_done))
    else $error("token started while busy or busy not set");

  a_frame_tick: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_frame_start |=> !o_frame_start [*8])
    else $error("frame tick repeated too soon");

  a_frame_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_frame_start |-> $past(frame_start_enable && host_capability_enable))
    else $error("frame tick while disabled");

endmodule : usb_sie_ctrl
`default_nettype wire

// ==== hdl/usb_sie_map.svh ====
// register offsets, field positions, reset values and timing counts of the
// link status and control block; included by the design file only.
// Overview of operation
// - load last endpoint number after each transfer
// - direction flag one for transmit, zero receive
// - bank flag one odd, zero even bank
// - live flag follows single-ended zero on lines
// - halt packets while set; setup token sets it
// - host enable switches on both line pull-downs
// - module enable attaches device with D+ pull-up
// - pointer clear forces all buffers to even
// - resume signalling while resume bit is set
// - host mode drives bus reset while set
// - host mode live flag shows J state
// - token busy high while token executes
// - host sends start-of-frame every millisecond
// - speed bit selects low speed, host only
// - seven-bit device address, software writable
// - token codes setup 1101, in 1001, out 0001
// - eight-bit frame threshold, ten plus packet size
// - upper byte and unused bits read zero
// - without OTG, pulls follow host and enable bits
`ifndef USB_SIE_MAP_SVH
`define USB_SIE_MAP_SVH
`define OFS_STAT 8'h00
`define OFS_CTRL 8'h04
`define OFS_ADDR 8'h08
`define OFS_TOK 8'h0C
`define OFS_SOF 8'h10
`define OFS_OTG 8'h14
`define BIT_CTRL_J_LEVEL 7
`define BIT_CTRL_SE0 6
`define BIT_CTRL_HALT 5
`define BIT_CTRL_BUSY 5
`define BIT_CTRL_BUSRST 4
`define BIT_CTRL_HOST 3
`define BIT_CTRL_RESUME 2
`define BIT_CTRL_PPCLR 1
`define BIT_CTRL_EN 0
`define BIT_ADDR_LS 7
`define BIT_OTG_EN 0
`define BIT_OTG_DPPU 7
`define BIT_OTG_DMPU 6
`define BIT_OTG_DPPD 5
`define BIT_OTG_DMPD 4
`define RST_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_PERIOD_NS 40
`define SOF_PERIOD_NS 1000000
`define SOF_CYCLES (`SOF_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ==== hdl/usb_sie_pkg.sv ====
// types shared by the link status and control block.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package usb_sie_pkg;
  typedef enum logic [3:0] {
    TOK_OUT = 4'h1,
    TOK_IN = 4'h9,
    TOK_SETUP = 4'hD
  } token_type_t;
  typedef enum logic [2:0] {
    SEL_STAT = 3'h0,
    SEL_CTRL = 3'h1,
    SEL_ADDR = 3'h2,
    SEL_TOK = 3'h3,
    SEL_SOF = 3'h4,
    SEL_OTG = 3'h5,
    SEL_NONE = 3'h7
  } reg_sel_t;
endpackage : usb_sie_pkg
`default_nettype wire
